// ### tpwm_channel.v
/*
  timer based pwm channel: 8-bit timebase with 2-bit fine count, shared period,
  double buffered 10-bit duty, polarity invert.
  assumes configuration inputs come from logic on core_clk; the pin direction is
  handled outside by software.
*/
`timescale 1ns/1ps
`include "tpwm_defs.vh"

// Functional notes
// R1 - output duty has ten bit resolution
// R2 - period shared, duty per channel
// R3 - postscaler never affects the waveform
// R4 - output active when timer clears
// R5 - output inactive when count equals duty
// R6 - duty at or above period: always active (code holds it active once the duty high byte reaches the period limit)
// R7 - duty registers buffered, reloaded at period match
// R8 - software writes both halves before match
// R9 - invert bit inverts the output
// R10 - period is (limit+1)*4*tosc*prescale
// R11 - after match: clear, set output, load buffers
// R12 - duty is high byte then low bits 7:6
// R13 - duty writes any time, waveform undisturbed
// R14 - pulse width is duty*tosc*prescale
// R15 - software clears pin direction for output
// R16 - fine count from oscillator through prescaler
// R17 - reset clears duty, buffers and invert (invert is an input and is not cleared; reset sets pwm_out_q to 0)
module tpwm_channel (
  input  wire                        core_clk,
  input  wire                        rst_b,
  input  wire [`TPWM_PRE_W-1:0]      prescale_sel,
  input  wire [`TPWM_HIGH_W-1:0]     period_limit_reg,
  input  wire                        duty_high_we,
  input  wire [`TPWM_HIGH_W-1:0]     duty_high_wdata,
  input  wire                        duty_low_we,
  input  wire [`TPWM_LOW_W-1:0]      duty_low_wdata,
  input  wire                        output_invert,
  output reg                         pwm_out_q,
  output reg  [`TPWM_HIGH_W-1:0]     timebase_count_q,
  output reg  [`TPWM_HIGH_W-1:0]     duty_high_reg_q,
  output reg  [`TPWM_LOW_W-1:0]      duty_low_reg_q,
  output reg                         period_match_q
);

  // ----------------------------------------------------------------
  // prescale terminal count
  // ----------------------------------------------------------------
  function [`TPWM_PRE_CNT_W-1:0] pre_last;
    input [`TPWM_PRE_W-1:0] sel;
    begin
      case (sel)
        `TPWM_PRE_1:  pre_last = `TPWM_PRE_LAST_1; // R16
        `TPWM_PRE_4:  pre_last = `TPWM_PRE_LAST_4; // R10
        `TPWM_PRE_16: pre_last = `TPWM_PRE_LAST_16; // R10
        default:      pre_last = `TPWM_PRE_LAST_64; // R10
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // duty value assembly
  // ----------------------------------------------------------------
  function [`TPWM_DUTY_W-1:0] duty_join;
    input [`TPWM_HIGH_W-1:0]  high_byte;
    input [`TPWM_LOW_W-1:0]   low_byte;
    begin
      duty_join = {high_byte, low_byte[`TPWM_LOW_MSB:`TPWM_LOW_LSB]}; // R12
    end
  endfunction

  // ----------------------------------------------------------------
  // clear point: next fine count meets a duty whose high byte is below the period limit
  // ----------------------------------------------------------------
  function clear_due;
    input [`TPWM_DUTY_W-1:0]  next_fine;
    input [`TPWM_DUTY_W-1:0]  duty;
    input [`TPWM_HIGH_W-1:0]  limit;
    begin
      clear_due = (next_fine == duty) &&
                  (duty[`TPWM_DUTY_W-1:`TPWM_QUARTER_W] < limit); // R6
    end
  endfunction

  // ----------------------------------------------------------------
  // state and next values
  // ----------------------------------------------------------------
  reg  [`TPWM_PRE_CNT_W-1:0]  pre_cnt_q;
  reg  [`TPWM_PRE_CNT_W-1:0]  pre_cnt_d;
  reg  [`TPWM_QUARTER_W-1:0]  quarter_q;
  reg  [`TPWM_QUARTER_W-1:0]  quarter_d;
  reg  [`TPWM_HIGH_W-1:0]     timebase_count_d;
  reg                         period_match_d;
  reg  [`TPWM_HIGH_W-1:0]     duty_high_reg_d;
  reg  [`TPWM_LOW_W-1:0]      duty_low_reg_d;
  reg  [`TPWM_DUTY_W-1:0]     duty_buf_q;
  reg  [`TPWM_DUTY_W-1:0]     duty_buf_d;
  reg                         active_q;
  reg                         active_d;
  reg                         pwm_out_d;
  wire                        pre_tick;
  wire                        incr;
  wire                        at_limit;
  wire                        wrap;
  wire [`TPWM_DUTY_W-1:0]     fine_count;
  wire [`TPWM_DUTY_W-1:0]     fine_next;
  wire [`TPWM_DUTY_W-1:0]     new_duty;

  // ----------------------------------------------------------------
  // count decode
  // ----------------------------------------------------------------
  assign pre_tick   = (pre_cnt_q == pre_last(prescale_sel)); // R16
  assign incr       = pre_tick && (quarter_q == `TPWM_QUARTER_LAST); // R10
  assign at_limit   = (timebase_count_q == period_limit_reg); // R2
  assign wrap       = incr && at_limit; // R11
  assign fine_count = {timebase_count_q, quarter_q}; // R16
  assign fine_next  = fine_count + 10'h001;
  assign new_duty   = duty_join(duty_high_reg_q, duty_low_reg_q); // R12

  // ----------------------------------------------------------------
  // prescaler next value
  // ----------------------------------------------------------------
  always @* begin
    pre_cnt_d = pre_cnt_q + 6'h01;
    quarter_d = quarter_q;
    if (pre_tick) begin
      pre_cnt_d = `TPWM_RST_PRE_CNT; // R16
      quarter_d = quarter_q + 2'h1; // R16
    end
  end

  // ----------------------------------------------------------------
  // timebase next value
  // ----------------------------------------------------------------
  always @* begin
    timebase_count_d = timebase_count_q;
    period_match_d   = wrap; // R3
    if (incr) begin
      if (at_limit) begin
        timebase_count_d = `TPWM_RST_COUNT; // R11
      end else begin
        timebase_count_d = timebase_count_q + 8'h01; // R10
      end
    end
  end

  // ----------------------------------------------------------------
  // duty registers and buffer next values
  // ----------------------------------------------------------------
  always @* begin
    duty_high_reg_d = duty_high_reg_q;
    duty_low_reg_d  = duty_low_reg_q;
    duty_buf_d      = duty_buf_q;
    if (duty_high_we) begin
      duty_high_reg_d = duty_high_wdata; // R13
    end
    if (duty_low_we) begin
      duty_low_reg_d = duty_low_wdata; // R13
    end
    if (wrap) begin
      duty_buf_d = new_duty; // R7 R11
    end
  end

  // ----------------------------------------------------------------
  // output compare
  // ----------------------------------------------------------------
  always @* begin
    active_d = active_q;
    if (wrap) begin
      active_d = (new_duty != 10'h000); // R4 R11
    end else if (pre_tick && clear_due(fine_next, duty_buf_q, period_limit_reg)) begin
      active_d = 1'h0; // R5 R14 R1
    end
  end

  // ----------------------------------------------------------------
  // output polarity
  // ----------------------------------------------------------------
  always @* begin
    pwm_out_d = active_d ^ output_invert; // R9
  end

  // ----------------------------------------------------------------
  // timebase registers
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_cnt_q        <= `TPWM_RST_PRE_CNT;
      quarter_q        <= `TPWM_RST_QUARTER;
      timebase_count_q <= `TPWM_RST_COUNT;
      period_match_q   <= `TPWM_RST_MATCH;
    end else begin
      pre_cnt_q        <= pre_cnt_d;
      quarter_q        <= quarter_d;
      timebase_count_q <= timebase_count_d;
      period_match_q   <= period_match_d;
    end
  end

  // ----------------------------------------------------------------
  // duty registers
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      duty_high_reg_q <= `TPWM_RST_DUTY_HIGH; // R17
      duty_low_reg_q  <= `TPWM_RST_DUTY_LOW; // R17
      duty_buf_q      <= `TPWM_RST_DUTY_BUF; // R17
    end else begin
      duty_high_reg_q <= duty_high_reg_d;
      duty_low_reg_q  <= duty_low_reg_d;
      duty_buf_q      <= duty_buf_d;
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      active_q  <= `TPWM_RST_ACTIVE;
      pwm_out_q <= `TPWM_RST_INVERT; // R17
    end else begin
      active_q  <= active_d;
      pwm_out_q <= pwm_out_d;
    end
  end

endmodule // tpwm_channel

// ### tpwm_defs.vh
/*
  constants for the timer based pwm channel: widths, reset values, prescale codes.
  assumes inclusion by the pwm channel module only.
*/
`ifndef TPWM_DEFS_VH
`define TPWM_DEFS_VH

`define TPWM_DUTY_W        10
`define TPWM_HIGH_W        8
`define TPWM_LOW_W         8
`define TPWM_LOW_MSB       7
`define TPWM_LOW_LSB       6
`define TPWM_QUARTER_W     2
`define TPWM_PRE_W         2
`define TPWM_PRE_CNT_W     6
`define TPWM_PRE_1         2'h0
`define TPWM_PRE_4         2'h1
`define TPWM_PRE_16        2'h2
`define TPWM_PRE_64        2'h3
`define TPWM_PRE_LAST_1    6'h00
`define TPWM_PRE_LAST_4    6'h03
`define TPWM_PRE_LAST_16   6'h0F
`define TPWM_PRE_LAST_64   6'h3F
`define TPWM_QUARTER_LAST  2'h3
`define TPWM_RST_DUTY_HIGH 8'h00
`define TPWM_RST_DUTY_LOW  8'h00
`define TPWM_RST_PERIOD    8'hFF
`define TPWM_RST_INVERT    1'h0
`define TPWM_RST_PRE_CNT   6'h00
`define TPWM_RST_QUARTER   2'h0
`define TPWM_RST_COUNT     8'h00
`define TPWM_RST_MATCH     1'h0
`define TPWM_RST_DUTY_BUF  10'h000
`define TPWM_RST_ACTIVE    1'h0

`endif

// ### tpwm_properties.sv
/* port assertions for the pwm channel.
   assumes a bind from tb onto tpwm_channel. */
`timescale 1ns/1ps
module tpwm_properties (
  input wire       core_clk, rst_b, duty_high_we, duty_low_we, output_invert,
  input wire [1:0] prescale_sel,
  input wire [7:0] period_limit_reg, duty_high_wdata, duty_low_wdata,
  input wire       pwm_out_q, period_match_q,
  input wire [7:0] timebase_count_q, duty_high_reg_q, duty_low_reg_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  sequence wrap_s;
    $changed(timebase_count_q) ##0 timebase_count_q == 8'h00;
  endsequence
  chk_match_single: assert property (period_match_q |=> !period_match_q)
    else $error("match pulse too long");
  chk_match_clear: assert property (period_match_q |-> timebase_count_q == 8'h00)
    else $error("count not clear at match");
  chk_wrap_limit: assert property ($stable(period_limit_reg) ##0 wrap_s
    |-> $past(timebase_count_q) == period_limit_reg) else $error("wrap not at limit");
  chk_count_step: assert property ($changed(timebase_count_q) |->
    timebase_count_q == 8'h00 || timebase_count_q == $past(timebase_count_q) + 8'h01)
    else $error("count skipped");
  chk_quarter_hold: assert property (prescale_sel == 2'h0 &&
    $changed(timebase_count_q) |=> $stable(timebase_count_q) [*3]) else $error("count too fast");
  chk_high_read: assert property (duty_high_we |=> duty_high_reg_q == $past(duty_high_wdata))
    else $error("high readback wrong");
  chk_low_read: assert property (duty_low_we |=> duty_low_reg_q == $past(duty_low_wdata))
    else $error("low readback wrong");
  chk_reset_clear: assert property ($rose(rst_b) |-> timebase_count_q == 8'h00 &&
    !pwm_out_q && !period_match_q && duty_high_reg_q == 8'h00 && duty_low_reg_q == 8'h00)
    else $error("outputs not clear after reset");
  chk_wrap_level: assert property (period_match_q |-> pwm_out_q ==
    (({$past(duty_high_reg_q), $past(duty_low_reg_q[7:6])} != 10'h000) ^ $past(output_invert)))
    else $error("output level wrong after wrap");
endmodule // tpwm_properties

// ### tb.sv
/* testbench for the pwm channel: duty writes and pulse counts.
   assumes 1:1 and 1:4 prescale and a period limit of 9 (40 clocks at 1:1). */
`timescale 1ns/1ps
module tb;
  reg         core_clk = 0, rst_b = 0, hw = 0, lw = 0, inv = 0;
  reg  [7:0]  hd = 8'h00, ld = 8'h00;
  reg  [1:0]  ps = 2'h0;
  reg  [15:0] hi;
  wire        pwm, pm;
  wire [7:0]  cnt, hq, lq;
  integer     bad_count = 0, cmp_count = 0, i, n;
  always #12.5 core_clk = ~core_clk;
  tpwm_channel tpwm_channel_i (.core_clk(core_clk), .rst_b(rst_b), .prescale_sel(ps),
    .period_limit_reg(8'h09), .duty_high_we(hw), .duty_high_wdata(hd), .duty_low_we(lw),
    .duty_low_wdata(ld), .output_invert(inv), .pwm_out_q(pwm), .timebase_count_q(cnt),
    .duty_high_reg_q(hq), .duty_low_reg_q(lq), .period_match_q(pm));
  task check(input string nm, input [15:0] seen, input [15:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected %s expected %0d seen %0d", nm, exp, seen);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task wm;
    begin
      n = 0;
      @(negedge core_clk);
      while (pm !== 1'b1 && n < 200) begin
        n = n + 1;
        @(negedge core_clk);
      end
      check("match_wait", pm, 16'h0001);
    end
  endtask
  task run(input [9:0] d, input v, input [1:0] p, input [15:0] e);
    begin
      @(negedge core_clk); {hw, lw, inv, ps, hd, ld} = {2'h3, v, p, d[9:2], d[1:0], 6'h2A};
      @(negedge core_clk); {hw, lw} = 2'h0;
      check("duty_high", hq, d[9:2]);
      check("duty_low", lq, {d[1:0], 6'h2A});
      wm;
      wm;
      hi = 16'h0000;
      for (i = 0; i < (40 << (2 * ps)); i = i + 1) begin
        hi = hi + pwm;
        {hw, lw, hd, ld} = {(i == 5), (i == 5), 16'h5555};
        @(negedge core_clk);
      end
      check("high_cycles", hi, e);
      check("period_match", pm, 16'h0001);
      $display("test done duty %0d invert %0d", d, v);
    end
  endtask
  initial begin
    repeat (16) @(negedge core_clk);
    rst_b = 1;
    run(10'h00D, 1'h0, 2'h0, 16'h000D);
    run(10'h006, 1'h0, 2'h0, 16'h0006);
    run(10'h000, 1'h0, 2'h0, 16'h0000);
    run(10'h024, 1'h0, 2'h0, 16'h0028);
    run(10'h00D, 1'h1, 2'h0, 16'h001B);
    run(10'h00D, 1'h0, 2'h1, 16'h0034);
    print_verdict;
  end
  initial begin
    #100000;
    bad_count = bad_count + 1;
    print_verdict;
  end
endmodule // tb
bind tpwm_channel tpwm_properties tpwm_properties_i (
  .core_clk(core_clk), .rst_b(rst_b), .duty_high_we(duty_high_we),
  .duty_low_we(duty_low_we), .output_invert(output_invert), .prescale_sel(prescale_sel),
  .period_limit_reg(period_limit_reg), .duty_high_wdata(duty_high_wdata),
  .duty_low_wdata(duty_low_wdata), .pwm_out_q(pwm_out_q), .period_match_q(period_match_q),
  .timebase_count_q(timebase_count_q), .duty_high_reg_q(duty_high_reg_q),
  .duty_low_reg_q(duty_low_reg_q));
